// file: rtl/pblc_top.sv
// Low pin bank configuration: four general purpose pins behind APB.
// Assumes an image loader outside supplies the stored configuration
// and a bus reset pulse; pins are synchronous to clk.
//
// Operation
// - Function-select bit zero makes the pin general purpose.
// - Buffer bit one gives push/pull, zero gives open-drain.
// - Direction bit one makes the pin output, zero input.
// - Push/pull output pins drive the last written data bit; open-drain ones only pull low.
// - Reading the data field returns sampled pin levels.
// - Only input pins may act as wake or interrupt sources.
// - A wake event also needs the pin's wake enable bit set.
// - Function select resets from image, else all ones.
// - Buffer type resets from image, else zero.
// - Direction resets from image, else zero, so inputs.
// - Data resets from image, else zero.
// - Bus or lite reset reloads fields from image or fallback.
// - Data read value of input pins is not the default.
// - Reset protection keeps fields across bus and lite resets.
`timescale 1ns/100ps
`default_nettype none
module pblc_top
  import pblc_pkg::*;
(
  input wire logic clk, // 10 MHz system clock
  input wire logic resetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, read or write of unmapped address
  input wire logic bus_reset, // Host bus reset pulse
  input wire pblc_cfg_t image_cfg, // Last loaded image
  input wire logic image_valid, // Image present
  input wire logic [3:0] pin_in, // Pin levels
  output logic [3:0] pin_out, // Pin output value
  output logic [3:0] pin_oe, // Pin output enable
  input wire logic [3:0] alt_out, // Alternate function value
  input wire logic [3:0] alt_oe, // Alternate function enable
  output logic [3:0] irq_src, // Qualified interrupt sources
  output logic wake_req // Any sticky wake status
);

  pblc_state_t st_reg;
  pblc_state_t st_next;
  logic [3:0] src_now;

  // Register address match, used for read and write paths
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // Configuration after a reset: image when present, else fallback
  function automatic pblc_cfg_t reload(input logic valid,
                                       input pblc_cfg_t img);
    reload = valid ? img : PBLC_CFG_FALLBACK;
  endfunction

  // Per-pin source qualification from registered state
  genvar gi;
  generate
    for (gi = 0; gi < PBLC_PINS; gi++)
    begin : g_src
      // Alternate-function pins never wake the device
      assign src_now[gi] = ~st_reg.cfg.fsel[gi]
        & ~st_reg.cfg.dir[gi]
        & (st_reg.pin_smp[gi] == st_reg.wake_pol[gi]);
    end
  endgenerate

  logic acc;
  logic wr;
  logic lite_rst;
  logic do_reload;

  // Next state
  always_comb
  begin
    st_next = st_reg;
    acc = psel & penable;
    wr = acc & pready & pwrite;
    lite_rst = wr & hit(paddr, PBLC_CTRL_OFS)
      & pwdata[PBLC_LITE_BIT];
    do_reload = 1'b0;
    st_next.pin_smp = pin_in;
    st_next.pready = acc & ~st_reg.pready;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;
    case (st_reg.fsm)
      PBLC_LOAD:
      begin
        // Image caught once after release, never under async reset
        do_reload = 1'b1;
        st_next.fsm = PBLC_RUN;
      end
      PBLC_RUN:
      begin
        // Reset wins over a write in the same cycle
        do_reload = (bus_reset | lite_rst) & ~st_reg.protect;
        if (wr && hit(paddr, PBLC_CFG_OFS) && !do_reload)
        begin
          // Upper half has no storage
          st_next.cfg.fsel = pwdata[PBLC_FSEL_LSB +: 4];
          st_next.cfg.buf_type = pwdata[PBLC_BUF_LSB +: 4];
          st_next.cfg.dir = pwdata[PBLC_DIR_LSB +: 4];
          st_next.cfg.data = pwdata[PBLC_DATA_LSB +: 4];
        end
        if (wr && hit(paddr, PBLC_WAKE_OFS))
        begin
          st_next.wake_en = pwdata[PBLC_WEN_LSB +: 4];
          st_next.wake_pol = pwdata[PBLC_WPOL_LSB +: 4];
        end
        if (wr && hit(paddr, PBLC_CTRL_OFS))
          st_next.protect = pwdata[PBLC_PROT_BIT];
        // Write one to clear; a new event wins over the clear
        if (wr && hit(paddr, PBLC_WSTS_OFS))
          st_next.wake_sts = st_reg.wake_sts & ~pwdata[3:0];
      end
      default:
        st_next.fsm = PBLC_LOAD;
    endcase
    if (do_reload)
      st_next.cfg = reload(image_valid, image_cfg);
    st_next.src = src_now;
    st_next.wake_sts = st_next.wake_sts
      | (src_now & st_reg.wake_en);
    st_next.wake = |st_next.wake_sts;
    // Read data answered one cycle into the access phase
    if (acc && !st_reg.pready)
    begin
      if (hit(paddr, PBLC_CFG_OFS))
        // Pins are read, not the stored value
        st_next.prdata = {16'h0000, st_reg.cfg.fsel,
          st_reg.cfg.buf_type, st_reg.cfg.dir, st_reg.pin_smp};
      else if (hit(paddr, PBLC_WAKE_OFS))
        st_next.prdata = {12'h000, st_reg.wake_pol,
          12'h000, st_reg.wake_en};
      else if (hit(paddr, PBLC_WSTS_OFS))
        st_next.prdata = {28'h0000000, st_reg.wake_sts};
      else if (hit(paddr, PBLC_CTRL_OFS))
        st_next.prdata = {31'h00000000, st_reg.protect};
      else
        st_next.pslverr = 1'b1;
    end
    // Pin drivers follow the next configuration
    for (int i = 0; i < PBLC_PINS; i++)
    begin
      if (st_next.cfg.fsel[i])
      begin
        st_next.pin_out[i] = alt_out[i];
        st_next.pin_oe[i] = alt_oe[i];
      end
      else if (st_next.cfg.buf_type[i])
      begin
        st_next.pin_out[i] = st_next.cfg.data[i];
        st_next.pin_oe[i] = st_next.cfg.dir[i];
      end
      else
      begin
        // Open-drain only ever pulls low
        st_next.pin_out[i] = 1'b0;
        st_next.pin_oe[i] = st_next.cfg.dir[i] & ~st_next.cfg.data[i];
      end
    end
  end

  // State register; async reset loads constants only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
      st_reg.fsm <= PBLC_LOAD;
      st_reg.cfg <= PBLC_CFG_FALLBACK;
      st_reg.wake_pol <= PBLC_WAKE_RST;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign pin_out = st_reg.pin_out;
  assign pin_oe = st_reg.pin_oe;
  assign irq_src = st_reg.src;
  assign wake_req = st_reg.wake;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic gp_rd;
  assign gp_rd = psel & penable & pready & ~pwrite
    & hit(paddr, PBLC_CFG_OFS);

  sequence s_cfg_write;
    psel && penable && pready && pwrite
      && hit(paddr, PBLC_CFG_OFS) && !bus_reset;
  endsequence

  sequence s_reload;
    st_reg.fsm == PBLC_RUN && bus_reset && !st_reg.protect;
  endsequence

  property p_fsel_write;
    s_cfg_write ##0 (st_reg.fsm == PBLC_RUN)
      |=> st_reg.cfg.fsel == $past(pwdata[15:12]);
  endproperty
  a_fsel_write: assert property (p_fsel_write)
    else $error("function select not written");

  property p_gp_enable;
    ((~st_reg.cfg.fsel) & pin_oe) == ((~st_reg.cfg.fsel)
      & st_reg.cfg.dir & (st_reg.cfg.buf_type | ~st_reg.cfg.data));
  endproperty
  a_gp_enable: assert property (p_gp_enable)
    else $error("pin enable does not match config");

  property p_pp_data;
    ((~st_reg.cfg.fsel) & st_reg.cfg.buf_type & pin_out)
      == ((~st_reg.cfg.fsel) & st_reg.cfg.buf_type
      & st_reg.cfg.data);
  endproperty
  a_pp_data: assert property (p_pp_data)
    else $error("push/pull pin value wrong");

  property p_od_low;
    ((~st_reg.cfg.fsel) & (~st_reg.cfg.buf_type) & pin_out) == 4'h0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain pin driven high");

  property p_rd_pins;
    gp_rd |-> prdata[3:0] == $past(pin_in, 2);
  endproperty
  a_rd_pins: assert property (p_rd_pins)
    else $error("data read is not the pin level");

  property p_rd_upper;
    gp_rd |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper bits read nonzero");

  property p_wake_qual;
    (st_reg.wake_sts & ~$past(st_reg.wake_sts)
      & $past(st_reg.cfg.dir | st_reg.cfg.fsel | ~st_reg.wake_en))
      == 4'h0;
  endproperty
  a_wake_qual: assert property (p_wake_qual)
    else $error("wake from unqualified pin");

  property p_reload;
    s_reload |=> st_reg.cfg == ($past(image_valid)
      ? $past(image_cfg) : PBLC_CFG_FALLBACK);
  endproperty
  a_reload: assert property (p_reload)
    else $error("bus reset did not reload config");

  property p_protect;
    bus_reset && st_reg.protect && st_reg.fsm == PBLC_RUN
      && !(psel && penable && pready && pwrite)
      |=> $stable(st_reg.cfg);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected config changed on reset");

  // Lite reset request completing while running
  sequence s_lite_req;
    st_reg.fsm == PBLC_RUN && psel && penable && pready && pwrite
      && hit(paddr, PBLC_CTRL_OFS) && pwdata[PBLC_LITE_BIT];
  endsequence

  property p_lite_reload;
    s_lite_req ##0 (!st_reg.protect)
      |=> st_reg.cfg == ($past(image_valid)
      ? $past(image_cfg) : PBLC_CFG_FALLBACK);
  endproperty
  a_lite_reload: assert property (p_lite_reload)
    else $error("lite reset did not reload config");

  // Protection must hold against the lite reset as well
  property p_lite_protect;
    s_lite_req ##0 st_reg.protect |=> $stable(st_reg.cfg);
  endproperty
  a_lite_protect: assert property (p_lite_protect)
    else $error("protected config changed on lite reset");

  // Output and alternate pins never show up as sources
  property p_irq_input;
    (irq_src & $past(st_reg.cfg.dir | st_reg.cfg.fsel)) == 4'h0;
  endproperty
  a_irq_input: assert property (p_irq_input)
    else $error("interrupt source from non-input pin");

  // A qualified event is never lost to a clear in the same cycle
  property p_sts_set_wins;
    (src_now & st_reg.wake_en) != 4'h0
      |=> (st_reg.wake_sts & $past(src_now & st_reg.wake_en))
      == $past(src_now & st_reg.wake_en);
  endproperty
  a_sts_set_wins: assert property (p_sts_set_wins)
    else $error("qualified wake event lost");

endmodule
`default_nettype wire

// file: rtl/pblc_pkg.sv
// Package for the low pin bank configuration block.
// Assumes a 32-bit APB slave and a 10 MHz system clock.
package pblc_pkg;
  localparam int unsigned PBLC_PINS = 4;
  // Byte offsets on the APB
  localparam logic [11:0] PBLC_CFG_OFS = 12'h018;
  localparam logic [11:0] PBLC_WAKE_OFS = 12'h020;
  localparam logic [11:0] PBLC_WSTS_OFS = 12'h024;
  localparam logic [11:0] PBLC_CTRL_OFS = 12'h028;
  // Field positions
  localparam int unsigned PBLC_FSEL_LSB = 12;
  localparam int unsigned PBLC_BUF_LSB = 8;
  localparam int unsigned PBLC_DIR_LSB = 4;
  localparam int unsigned PBLC_DATA_LSB = 0;
  localparam int unsigned PBLC_WEN_LSB = 0;
  localparam int unsigned PBLC_WPOL_LSB = 16;
  localparam int unsigned PBLC_PROT_BIT = 0;
  localparam int unsigned PBLC_LITE_BIT = 1;
  // Fallback values when no image is present, and the wake polarity async reset value
  localparam logic [3:0] PBLC_FSEL_RST = 4'hf;
  localparam logic [3:0] PBLC_BUF_RST = 4'h0;
  localparam logic [3:0] PBLC_DIR_RST = 4'h0;
  localparam logic [3:0] PBLC_DATA_RST = 4'h0;
  localparam logic [3:0] PBLC_WAKE_RST = 4'h0;

  typedef enum logic [1:0] {
    PBLC_LOAD = 2'b01,
    PBLC_RUN = 2'b10
  } pblc_fsm_t;

  // One pin bank configuration word
  typedef struct packed {
    logic [3:0] fsel;
    logic [3:0] buf_type;
    logic [3:0] dir;
    logic [3:0] data;
  } pblc_cfg_t;

  // Whole block state
  typedef struct packed {
    pblc_fsm_t fsm;
    pblc_cfg_t cfg;
    logic [3:0] wake_en;
    logic [3:0] wake_pol;
    logic [3:0] wake_sts;
    logic protect;
    logic [3:0] pin_smp;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] src;
    logic wake;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pblc_state_t;

  localparam pblc_cfg_t PBLC_CFG_FALLBACK =
    {PBLC_FSEL_RST, PBLC_BUF_RST, PBLC_DIR_RST, PBLC_DATA_RST};
endpackage

// file: tb/pblc_top_tb.sv
// Self-checking bench for the low pin bank configuration block.
// Assumes pblc_pkg and pblc_top are compiled first; one 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module pblc_top_tb;
  import pblc_pkg::*;
  typedef struct packed {
    logic [31:0] wr;
    logic [3:0] pin;
    logic [3:0] out;
    logic [3:0] oe;
  } pblc_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_reset = 1'b0;
  pblc_cfg_t image_cfg = 16'h3a5c;
  logic image_valid = 1'b0;
  logic [3:0] pin_in = 4'h0;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic [3:0] alt_out = 4'h6;
  logic [3:0] alt_oe = 4'h9;
  logic [3:0] irq_src;
  logic wake_req;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int checks = 0;
  // Ordinary cases: word written, pin levels, expected pin drive
  pblc_row_t rows [5] = '{
    '{32'h0000_0f35, 4'ha, 4'h5, 4'h3},
    '{32'h0000_00f5, 4'h3, 4'h0, 4'ha},
    '{32'h0000_0afc, 4'h5, 4'h8, 4'hb},
    '{32'h0000_5fff, 4'h0, 4'he, 4'hb},
    '{32'hffff_0000, 4'h6, 4'h0, 4'h0}};

  pblc_top pblc_top_inst (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_reset(bus_reset), .image_cfg(image_cfg),
    .image_valid(image_valid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
    .irq_src(irq_src), .wake_req(wake_req));

  // 100 ns clock
  always #50 clk = ~clk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; pready and data taken at the same sampling edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk("pready", 1, 0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never lands in this time step
    @(posedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic pulse_bus_reset;
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    @(posedge clk);
  endtask

  // Watchdog: the whole run needs well under 1000 cycles
  initial
  begin
    #500000;
    n_fail++;
    complete_run;
  end

  initial
  begin
    repeat (2) @(posedge clk);
    chk("oe in reset", 4'h0, pin_oe);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    // Fallback: all pins alternate, others zero
    chk("out fallback", alt_out, pin_out);
    chk("oe fallback", alt_oe, pin_oe);
    rdchk("cfg fallback", PBLC_CFG_OFS, 32'h0000_f000);
    $display("test reset done");
    foreach (rows[i])
    begin
      pin_in <= rows[i].pin;
      apb(1'b1, PBLC_CFG_OFS, rows[i].wr);
      repeat (3) @(posedge clk);
      chk("pin_out", rows[i].out, pin_out);
      chk("pin_oe", rows[i].oe, pin_oe);
      // Data field reads the pins, not the stored bits
      rdchk("cfg", PBLC_CFG_OFS,
        {16'h0, rows[i].wr[15:4], rows[i].pin});
    end
    $display("test table done");
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped err", 1, er);
    $display("test unmapped done");
    // Inputs with matching level flag; enabled one wakes
    pin_in <= 4'h3;
    apb(1'b1, PBLC_CFG_OFS, 32'h0);
    apb(1'b1, PBLC_WAKE_OFS, 32'h000f_0001);
    repeat (3) @(posedge clk);
    chk("irq all in", 4'h3, irq_src);
    chk("wake", 1, wake_req);
    rdchk("wake reg", PBLC_WAKE_OFS, 32'h000f_0001);
    apb(1'b1, PBLC_CFG_OFS, 32'h0000_0020);
    repeat (3) @(posedge clk);
    chk("irq pin1 out", 4'h1, irq_src);
    // Pin 0 still qualifies, so its status survives the clear
    apb(1'b1, PBLC_WSTS_OFS, 32'h0000_000f);
    rdchk("sts kept", PBLC_WSTS_OFS, 32'h0000_0001);
    chk("wake kept", 1, wake_req);
    apb(1'b1, PBLC_WAKE_OFS, 32'h000f_0000);
    apb(1'b1, PBLC_WSTS_OFS, 32'h0000_000f);
    repeat (3) @(posedge clk);
    chk("wake off", 0, wake_req);
    $display("test wake done");
    // Lite reset reloads the image
    pin_in <= 4'h0;
    image_valid <= 1'b1;
    apb(1'b1, PBLC_CTRL_OFS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    rdchk("lite reload", PBLC_CFG_OFS, 32'h0000_3a50);
    // Protected fields survive a bus reset
    apb(1'b1, PBLC_CTRL_OFS, 32'h0000_0001);
    apb(1'b1, PBLC_CFG_OFS, 32'h0000_0000);
    pulse_bus_reset;
    rdchk("protected", PBLC_CFG_OFS, 32'h0);
    // Lite reset is blocked too; the lite bit reads back zero
    apb(1'b1, PBLC_CTRL_OFS, 32'h0000_0003);
    rdchk("protected lite", PBLC_CFG_OFS, 32'h0);
    rdchk("ctrl", PBLC_CTRL_OFS, 32'h0000_0001);
    apb(1'b1, PBLC_CTRL_OFS, 32'h0);
    pulse_bus_reset;
    rdchk("bus reload", PBLC_CFG_OFS, 32'h0000_3a50);
    $display("test image done");
    // Async reset with no image falls back again
    resetn <= 1'b0;
    image_valid <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdchk("cfg rereset", PBLC_CFG_OFS, 32'h0000_f000);
    $display("test rereset done");
    complete_run;
  end
endmodule
`default_nettype wire
